// ===== hdl/i2cs_consts.vh
// register map, field positions, reset values and timing constants of the two-wire controller
`ifndef I2CS_CONSTS_VH
`define I2CS_CONSTS_VH
// ==========================================
// register offsets (byte addresses)
`define I2CS_SOFT_RESET_KEY_OFF 9'h040
`define I2CS_CONTROL_OFF        9'h100
`define I2CS_STATUS_WORD_OFF    9'h104
// ==========================================
// control field positions
`define I2CS_CTL_EN    0
`define I2CS_CTL_TXRST 1
`define I2CS_CTL_MASTER   2
`define I2CS_CTL_TX       3
`define I2CS_CTL_ACK_VAL  4
`define I2CS_CTL_RESTART  5
`define I2CS_CTL_GEN_CALL 6
`define I2CS_CTL_RESET    7'h00
// status_word field positions
`define I2CS_STAT_BUSY    2
// ==========================================
// soft reset key and pulse
`define I2CS_RESET_KEY   4'ha
`define I2CS_RST_PULSE   3'h4
// ==========================================
// bus answers
`define I2CS_RESP_OKAY   2'h0
`define I2CS_RESP_SLVERR 2'h2
// ==========================================
// timing: system clock period and quarter bit time of generated conditions
`define I2CS_CLK_NS      100
`define I2CS_QTR_NS      2500
// general call address
`define I2CS_GC_ADDR     8'h00
`endif

// ===== hdl/i2cs_sync2.v
// two flip-flop synchroniser for asynchronous pin inputs
module i2cs_sync2 #(
   parameter WIDTH = 2
) (
   input  wire             mclk,
   input  wire             nrst,
   input  wire [WIDTH-1:0] d,
   output wire [WIDTH-1:0] q
);
   reg [WIDTH-1:0] meta_r;
   reg [WIDTH-1:0] sync_r;

   // first stage feeds only the second; pins idle high
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         meta_r <= {WIDTH{1'b1}};
         sync_r <= {WIDTH{1'b1}};
      end else begin
         meta_r <= d;
         sync_r <= meta_r;
      end
   end
   assign q = sync_r;
endmodule // i2cs_sync2

// ===== hdl/i2cs_ctrl.v
// two-wire controller: soft reset key, control register and bus condition engine
`include "i2cs_consts.vh"

module i2cs_ctrl #(
   parameter [6:0] OWN_ADDR = 7'h10
) (
   input  wire        mclk,
   input  wire        nrst,
   // register port
   input  wire [8:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [8:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // two-wire bus, open drain
   input  wire        scl_i,
   output wire        scl_o,
   output wire        scl_oe,
   input  wire        sda_i,
   output wire        sda_o,
   output wire        sda_oe,
   // slave receive data
   output reg  [7:0]  rx_byte,
   output reg         rx_valid
);
   localparam integer QTR_CYC = (`I2CS_QTR_NS + `I2CS_CLK_NS - 1) / `I2CS_CLK_NS;
   localparam [7:0]   QTR     = QTR_CYC[7:0];
   // master engine states
   localparam [3:0] M_IDLE = 4'h0, M_STA1 = 4'h1, M_STA2 = 4'h2, M_HOLD = 4'h3,
                    M_RS1  = 4'h4, M_RS2  = 4'h5, M_SP1  = 4'h6, M_SP2  = 4'h7,
                    M_SP3  = 4'h8;

   // ==========================================
   // declarations
   reg  [2:0] srst_cnt_r;
   reg  [6:0] ctl_r;
   reg  [3:0] mst_r, bit_cnt_r;
   reg  [7:0] tmr_r, shf_r;
   reg  [1:0] pin_d_r;
   reg        busy_r, m_scl_low_r, m_sda_low_r, mode_clr_r, rep_clr_r;
   reg        addr_ph_r, addressed_r, ack_drv_r;
   wire [1:0] pin_s;
   wire       soft_rst = (srst_cnt_r != 3'h0);
   wire       en       = ctl_r[`I2CS_CTL_EN];
   wire       wr_hs    = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid & ~soft_rst;
   wire       scl_s    = pin_s[1];
   wire       sda_s    = pin_s[0];
   wire       scl_rise = scl_s & ~pin_d_r[1];
   wire       scl_fall = ~scl_s & pin_d_r[1];
   wire       sta_det  = scl_s & pin_d_r[1] & ~sda_s & pin_d_r[0];
   wire       sto_det  = scl_s & pin_d_r[1] & sda_s & ~pin_d_r[0];
   wire       tmr_done = (tmr_r == 8'h00);

   // ==========================================
   // pin synchronisers
   i2cs_sync2 #(.WIDTH(2)) u_sync (
      .mclk (mclk),
      .nrst (nrst),
      .d    ({scl_i, sda_i}),
      .q    (pin_s)
   );

   // open-drain drive: only ever pull low
   assign scl_o  = 1'b0;
   assign sda_o  = 1'b0;
   assign scl_oe = m_scl_low_r;
   assign sda_oe = m_sda_low_r | ack_drv_r;

   // ==========================================
   // register port handshakes
   assign s_axi_awready = wr_hs;
   assign s_axi_wready  = wr_hs;
   assign s_axi_arready = ~s_axi_rvalid;

   // write answer and soft reset pulse
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         srst_cnt_r   <= 3'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `I2CS_RESP_OKAY;
      end else begin
         if (s_axi_bvalid & s_axi_bready)
            s_axi_bvalid <= 1'b0;
         if (soft_rst) begin
            srst_cnt_r <= srst_cnt_r - 3'h1;
            if (srst_cnt_r == 3'h1) begin
               s_axi_bvalid <= 1'b1;
               s_axi_bresp  <= `I2CS_RESP_OKAY;
            end
         end else if (wr_hs) begin
            if (s_axi_awaddr == `I2CS_SOFT_RESET_KEY_OFF) begin
               if (s_axi_wdata[3:0] == `I2CS_RESET_KEY) begin
                  srst_cnt_r <= `I2CS_RST_PULSE;
               end else begin
                  s_axi_bvalid <= 1'b1;
                  s_axi_bresp  <= `I2CS_RESP_SLVERR;
               end
            end else begin
               s_axi_bvalid <= 1'b1;
               s_axi_bresp  <= (s_axi_awaddr == `I2CS_CONTROL_OFF ||
                                s_axi_awaddr == `I2CS_STATUS_WORD_OFF) ?
                               `I2CS_RESP_OKAY : `I2CS_RESP_SLVERR;
            end
         end
      end
   end

   // read answer
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= `I2CS_RESP_OKAY;
      end else if (s_axi_rvalid) begin
         if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end else if (s_axi_arvalid) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= `I2CS_RESP_OKAY;
         case (s_axi_araddr)
            `I2CS_CONTROL_OFF:        s_axi_rdata <= {25'h0, ctl_r};
            `I2CS_STATUS_WORD_OFF:    s_axi_rdata <= {29'h0, busy_r, 2'h0};
            `I2CS_SOFT_RESET_KEY_OFF: s_axi_rdata <= 32'h0000_0000;
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= `I2CS_RESP_SLVERR;
            end
         endcase
      end
   end

   // control register: software write, then hardware self-clears MASTER and RESTART
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         ctl_r <= `I2CS_CTL_RESET;
      end else if (soft_rst) begin
         ctl_r <= `I2CS_CTL_RESET;
      end else begin
         if (wr_hs && s_axi_awaddr == `I2CS_CONTROL_OFF && s_axi_wstrb[0])
            ctl_r <= s_axi_wdata[6:0];
         if (mode_clr_r)
            ctl_r[`I2CS_CTL_MASTER] <= 1'b0;
         if (rep_clr_r)
            ctl_r[`I2CS_CTL_RESTART] <= 1'b0;
      end
   end

   // ==========================================
   // bus monitor: edges and busy flag
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         pin_d_r <= 2'h3;
         busy_r  <= 1'b0;
      end else begin
         pin_d_r <= pin_s;
         if (soft_rst)
            busy_r <= 1'b0;
         else if (sta_det)
            busy_r <= 1'b1;
         else if (sto_det)
            busy_r <= 1'b0;
      end
   end

   // ==========================================
   // master condition engine: START, repeated START, STOP
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         mst_r       <= M_IDLE;
         tmr_r       <= 8'h00;
         m_scl_low_r <= 1'b0;
         m_sda_low_r <= 1'b0;
         mode_clr_r  <= 1'b0;
         rep_clr_r   <= 1'b0;
      end else if (soft_rst || !en) begin
         mst_r       <= M_IDLE;
         tmr_r       <= 8'h00;
         m_scl_low_r <= 1'b0;
         m_sda_low_r <= 1'b0;
         mode_clr_r  <= 1'b0;
         rep_clr_r   <= 1'b0;
      end else begin
         mode_clr_r <= 1'b0;
         rep_clr_r  <= 1'b0;
         if (!tmr_done)
            tmr_r <= tmr_r - 8'h01;
         case (mst_r)
            M_IDLE: begin
               if (ctl_r[`I2CS_CTL_RESTART] && !mode_clr_r && !rep_clr_r) begin
                  mode_clr_r <= 1'b1;
                  rep_clr_r  <= 1'b1;
               end else if (ctl_r[`I2CS_CTL_MASTER] && !mode_clr_r) begin
                  if (busy_r) begin
                     mode_clr_r <= 1'b1;
                  end else begin
                     mst_r       <= M_STA1;
                     m_sda_low_r <= 1'b1;
                     tmr_r       <= QTR;
                  end
               end
            end
            M_STA1: if (tmr_done) begin
               if (ctl_r[`I2CS_CTL_RESTART])
                  rep_clr_r <= 1'b1;
               mst_r       <= M_STA2;
               m_scl_low_r <= 1'b1;
               tmr_r       <= QTR;
            end
            M_STA2: if (tmr_done)
               mst_r <= M_HOLD;
            M_HOLD: begin
               if (!ctl_r[`I2CS_CTL_MASTER]) begin
                  mst_r <= M_SP1;
                  tmr_r <= QTR;
               end else if (ctl_r[`I2CS_CTL_RESTART]) begin
                  mst_r       <= M_RS1;
                  m_sda_low_r <= 1'b0;
                  tmr_r       <= QTR;
               end
            end
            M_RS1: if (tmr_done) begin
               mst_r       <= M_RS2;
               m_scl_low_r <= 1'b0;
               tmr_r       <= QTR;
            end
            M_RS2: begin
               if (!sda_s) begin
                  mst_r      <= M_IDLE;
                  mode_clr_r <= 1'b1;
                  rep_clr_r  <= 1'b1;
               end else if (tmr_done) begin
                  mst_r       <= M_STA1;
                  m_sda_low_r <= 1'b1;
                  tmr_r       <= QTR;
               end
            end
            M_SP1: begin
               m_sda_low_r <= 1'b1;
               if (tmr_done) begin
                  mst_r       <= M_SP2;
                  m_scl_low_r <= 1'b0;
                  tmr_r       <= QTR;
               end
            end
            M_SP2: if (tmr_done) begin
               mst_r       <= M_SP3;
               m_sda_low_r <= 1'b0;
               tmr_r       <= QTR;
            end
            M_SP3: if (tmr_done)
               mst_r <= M_IDLE;
            default: mst_r <= M_IDLE;
         endcase
      end
   end

   // ==========================================
   // slave receiver: address match and acknowledge slot
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         bit_cnt_r   <= 4'h0;
         shf_r       <= 8'h00;
         addr_ph_r   <= 1'b0;
         addressed_r <= 1'b0;
         ack_drv_r   <= 1'b0;
         rx_byte     <= 8'h00;
         rx_valid    <= 1'b0;
      end else if (soft_rst || !en) begin
         bit_cnt_r   <= 4'h0;
         addr_ph_r   <= 1'b0;
         addressed_r <= 1'b0;
         ack_drv_r   <= 1'b0;
         rx_valid    <= 1'b0;
      end else begin
         rx_valid <= 1'b0;
         if (sta_det) begin
            bit_cnt_r   <= 4'h0;
            addr_ph_r   <= 1'b1;
            addressed_r <= 1'b0;
            ack_drv_r   <= 1'b0;
         end else if (sto_det) begin
            addr_ph_r   <= 1'b0;
            addressed_r <= 1'b0;
            ack_drv_r   <= 1'b0;
         end else if (addr_ph_r || addressed_r) begin
            if (scl_rise && bit_cnt_r < 4'h8) begin
               shf_r     <= {shf_r[6:0], sda_s};
               bit_cnt_r <= bit_cnt_r + 4'h1;
            end else if (scl_rise && bit_cnt_r == 4'h8) begin
               bit_cnt_r <= 4'h9;
            end else if (scl_fall && bit_cnt_r == 4'h8) begin
               if (addr_ph_r) begin
                  addr_ph_r <= 1'b0;
                  if ((shf_r[7:1] == OWN_ADDR && !shf_r[0]) ||
                      (ctl_r[`I2CS_CTL_GEN_CALL] && shf_r == `I2CS_GC_ADDR)) begin
                     addressed_r <= 1'b1;
                     ack_drv_r   <= 1'b1;
                  end else begin
                     bit_cnt_r <= 4'h0;
                  end
               end else begin
                  rx_byte   <= shf_r;
                  rx_valid  <= 1'b1;
                  ack_drv_r <= ~ctl_r[`I2CS_CTL_ACK_VAL];
               end
            end else if (scl_fall && bit_cnt_r == 4'h9) begin
               ack_drv_r <= 1'b0;
               bit_cnt_r <= 4'h0;
            end
         end
      end
   end
endmodule // i2cs_ctrl

// ===== verification/i2cs_ctrl_sva.sv
// checker of the two-wire controller register port and bus pins
module i2cs_ctrl_sva (
   input wire        mclk,
   input wire        nrst,
   input wire [8:0]  s_axi_awaddr,
   input wire        s_axi_awvalid,
   input wire        s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0]  s_axi_wstrb,
   input wire        s_axi_wvalid,
   input wire        s_axi_wready,
   input wire [1:0]  s_axi_bresp,
   input wire        s_axi_bvalid,
   input wire [8:0]  s_axi_araddr,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire        s_axi_rvalid,
   input wire        scl_oe,
   input wire        sda_oe,
   input wire        rx_valid
);
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================
   // taken requests and key writes
   wire wt  = s_axi_awvalid && s_axi_wvalid && s_axi_awready;
   wire rt  = s_axi_arvalid && s_axi_arready;
   wire kw  = wt && s_axi_awaddr == 9'h040;
   wire key = kw && s_axi_wdata[3:0] == 4'ha;
   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);
   property p_key_resp;
      key |=> !s_axi_bvalid [*4] ##1 (s_axi_bvalid && s_axi_bresp == 2'h0);
   endproperty
   a_key_resp: assert property (p_key_resp) else $error("key answer timing");
   property p_key_hold;
      key |=> (!s_axi_awready && !s_axi_wready) [*4];
   endproperty
   a_key_hold: assert property (p_key_hold) else $error("write taken in pulse");
   property p_bad_key;
      kw && s_axi_wdata[3:0] != 4'ha |=> s_axi_bvalid && s_axi_bresp == 2'h2;
   endproperty
   a_bad_key: assert property (p_bad_key) else $error("wrong key not refused");
   property p_pins;
      key |=> ##[0:4] !(scl_oe || sda_oe);
   endproperty
   a_pins: assert property (p_pins) else $error("pins held after soft reset");
   property p_rd_key;
      rt && s_axi_araddr == 9'h040 |=> s_axi_rvalid && s_axi_rdata == 32'h0;
   endproperty
   a_rd_key: assert property (p_rd_key) else $error("key register readable");
   property p_rsv;
      rt && s_axi_araddr == 9'h100 |=> s_axi_rdata[31:7] == 25'h0;
   endproperty
   a_rsv: assert property (p_rsv) else $error("reserved control bits set");
   property p_en_off;
      wt && s_axi_awaddr == 9'h100 && s_axi_wstrb[0] && !s_axi_wdata[0]
         |=> ##[0:4] !(scl_oe || sda_oe);
   endproperty
   a_en_off: assert property (p_en_off) else $error("pins held while disabled");
   property p_rx;
      rx_valid |=> !rx_valid;
   endproperty
   a_rx: assert property (p_rx) else $error("byte strobe too long");
endmodule // i2cs_ctrl_sva

bind i2cs_ctrl i2cs_ctrl_sva chk (.mclk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
   .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .scl_oe,
   .sda_oe, .rx_valid);

// ===== verification/i2cs_bus_agent.sv
// outside bus master model pulling the two-wire lines low
module i2cs_bus_agent (
   input  wire logic scl,
   input  wire logic sda,
   output logic      scl_pull,
   output logic      sda_pull
);
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================
   // lines released at start, clock stands high between frames
   initial begin
      scl_pull = 0;
      sda_pull = 0;
   end
   // one 800 ns bit slot, entered and left with the clock low
   task automatic slot(input logic b, output logic s);
      #200 sda_pull = !b;
      #300 scl_pull = 0;
      #150 s = sda;
      #150 scl_pull = 1;
   endtask
   // start, address, data, stop; returns both acknowledge levels
   task automatic xfer(input logic [7:0] a, d, output logic aa, da);
      logic s;
      #13 sda_pull = 1;
      #400 scl_pull = 1;
      for (int i = 7; i >= 0; i--) slot(a[i], s);
      slot(1, aa);
      for (int i = 7; i >= 0; i--) slot(d[i], s);
      slot(1, da);
      #200 sda_pull = 1;
      #300 scl_pull = 0;
      #300 sda_pull = 0;
      #400;
   endtask
   // hold the bus with a bare start, then let go with a stop
   task automatic grab();
      sda_pull = 1;
   endtask
   task automatic free();
      sda_pull = 0;
   endtask
endmodule // i2cs_bus_agent

// ===== verification/tb_i2c_ctrl_softreset_regs.sv
// self-checking bench of soft reset and upper control bits
module tb_i2c_ctrl_softreset_regs;
   timeunit 1ns;
   timeprecision 1ns;
   logic        mclk, nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_bvalid;
   logic        s_axi_arvalid, s_axi_rready, s_axi_rvalid, s_axi_awready, s_axi_wready;
   logic        s_axi_arready, scl_oe, sda_oe, scl_pull, sda_pull, rx_valid, a1, a2;
   logic        scl_o, sda_o;
   logic [8:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [7:0]  rx_byte;
   logic [33:0] exp_q[$];
   integer      miscompares, checks, seed, cyc;
   wire         scl = !(scl_pull | (scl_oe & !scl_o));
   wire         sda = !(sda_pull | (sda_oe & !sda_o));
   // design and far-side master on pulled-up lines
   i2cs_ctrl #(.OWN_ADDR(7'h10)) dut (.mclk, .nrst, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .scl_i(scl), .scl_o, .scl_oe, .sda_i(sda), .sda_o, .sda_oe, .rx_byte, .rx_valid);
   i2cs_bus_agent agent (.scl, .sda, .scl_pull, .sda_pull);
   initial begin
      mclk = 0;
      forever #50 mclk = ~mclk;
   end
   // ==========================================
   // checking and closing
   task automatic check(input string what, input logic [33:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   function automatic logic [33:0] nx();
      return exp_q.size() ? exp_q.pop_front() : 34'hx;
   endfunction
   task automatic report_and_stop();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // random answer stalls at the falling edge
   always @(negedge mclk) begin
      s_axi_bready <= $random(seed);
      s_axi_rready <= $random(seed);
   end
   // answers and received bytes against the oldest note, plus cycle limit
   always @(posedge mclk) if (nrst === 1'b1) begin
      cyc++;
      if ((s_axi_bvalid & s_axi_bready) === 1'b1)
         check("write", {s_axi_bresp, 32'h0}, nx());
      if ((s_axi_rvalid & s_axi_rready) === 1'b1)
         check("read", {s_axi_rresp, s_axi_rdata}, nx());
      if (rx_valid === 1'b1) check("rx byte", {26'h0, rx_byte}, nx());
      if (cyc > 20000) begin
         miscompares++;
         report_and_stop();
      end
   end
   // one access: hold until taken, then wait for the answer
   task automatic acc(input logic w, input logic [8:0] a, input logic [31:0] wd,
                      input logic [33:0] e);
      int n;
      exp_q.push_back(e);
      @(negedge mclk);
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = {a, a, wd};
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = {w, w, !w};
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (!(w ? s_axi_awready : s_axi_arready) && n < 200);
      @(negedge mclk);
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
      while (exp_q.size()) @(negedge mclk);
   endtask
   // one frame from the far-side master, acks compared
   task automatic slv(input logic [7:0] a, input logic ea, ed, rx);
      logic [7:0] b;
      b = $random(seed);
      if (rx) exp_q.push_back({26'h0, b});
      agent.xfer(a, b, a1, a2);
      check("address ack", a1, ea);
      check("data ack", a2, ed);
   endtask
   // ==========================================
   // scenarios
   initial begin
      seed = 72;
      {miscompares, checks, cyc} = 0;
      {nrst, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0;
      s_axi_wstrb = 4'hf;
      repeat (3) @(posedge mclk);
      @(negedge mclk) nrst = 1;
      acc(0, 9'h100, 0, 34'h0);
      acc(0, 9'h040, 0, 34'h0);
      acc(0, 9'h0fc, 0, 34'h2_0000_0000);
      d = $random(seed) & ~32'h24;
      acc(1, 9'h100, d, 34'h0);
      acc(0, 9'h100, 0, {27'h0, d[6:0]});
      $display("defaults and control bits done");
      for (int k = 0; k < 16; k++)
         if (k != 10) acc(1, 9'h040, ($random(seed) & ~32'hf) | k, 34'h2_0000_0000);
      acc(0, 9'h100, 0, {27'h0, d[6:0]});
      acc(1, 9'h040, ($random(seed) & ~32'hf) | 32'ha, 34'h0);
      acc(0, 9'h100, 0, 34'h0);
      $display("soft reset key done");
      acc(1, 9'h100, 32'h1, 34'h0);
      slv(8'h20, 0, 0, 1);
      slv(8'h00, 1, 1, 0);
      acc(1, 9'h100, 32'h51, 34'h0);
      slv(8'h00, 0, 1, 1);
      acc(1, 9'h100, 32'h40, 34'h0);
      slv(8'h20, 1, 1, 0);
      $display("slave receive done");
      acc(1, 9'h100, 32'h5, 34'h0);
      repeat (60) @(negedge mclk);
      check("start lines", {scl, sda}, 2'b00);
      acc(0, 9'h104, 0, 34'h4);
      acc(1, 9'h100, 32'h25, 34'h0);
      repeat (120) @(negedge mclk);
      check("restart lines", {scl, sda}, 2'b00);
      acc(0, 9'h100, 0, 34'h5);
      acc(1, 9'h100, 32'h1, 34'h0);
      repeat (100) @(negedge mclk);
      check("stop lines", {scl, sda}, 2'b11);
      acc(0, 9'h104, 0, 34'h0);
      $display("master conditions done");
      agent.grab();
      repeat (10) @(negedge mclk);
      acc(0, 9'h104, 0, 34'h4);
      acc(1, 9'h100, 32'h5, 34'h0);
      repeat (5) @(negedge mclk);
      check("lost pins", {scl_oe, sda_oe}, 2'b00);
      acc(0, 9'h100, 0, 34'h1);
      acc(1, 9'h040, 32'ha, 34'h0);
      acc(0, 9'h104, 0, 34'h0);
      agent.free();
      acc(1, 9'h100, 32'h21, 34'h0);
      repeat (5) @(negedge mclk);
      acc(0, 9'h100, 0, 34'h1);
      $display("held bus and refused restart done");
      report_and_stop();
   end
endmodule // tb_i2c_ctrl_softreset_regs
